// File: rtl/sequencer_step_actions.sv
// What this block does
// R1: Act on regulator at its step going up and again going down.
// R2: All regulators sharing a step are acted on within that step.
// R3: Up pass, auto or keep set: enable regulator, select A setting.
// R4: Keep clear: disable regulator, select A (up only when auto clear too).
// R5: Down pass with keep set: stay enabled, switch to B setting.
// R6: Default supply set: step 0 regulators enabled on entering low power.
// R7: Other steps enable only after wakeup; step 0 otherwise normal.
// R8: Default supply clear: step 0 does nothing.
// R9: First linear regulator stays on in reset if all three settings set.
// R10: Each output asserted at its rise step, deasserted at fall step.
// R11: In reset mode all sequencer outputs go inactive.
// R12: Output actions only at steps above zero.
// R13: Polarity sets active level; up pass rise=active, fall=inactive.
// R14: Down pass reverses output actions.
// R15: A wait step above zero holds until wait input event.
// R16: Host clears wait event flag after power-up completes.
// R17: Wait timeout expiry skips later steps, starts shutdown, sets flag.
// R18: Wait step may instead act as a configurable delay.
// R19: Group enabled above disable step going up, disabled below going down.
// R20: Sixteen steps; step period programmable 32 us to 8.192 ms.
// R21: Pointers above final step uncontrolled; non-regulator step 0 disables.
// R22: Power-down runs the power-up sequence in reverse.
// R23: Actions evaluated once per step tick for current step and direction.
// R24: While waiting, regulators and outputs stay unchanged.
`default_nettype none
module sequencer_step_actions
    import seq_step_pkg::*;
#(
    parameter int N_REG       = NUM_REGS,
    parameter int N_OUT       = NUM_OUTS,
    parameter int TIMEOUT_CNT = TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Step counter
    input  wire logic                          step_tick_i,
    input  wire logic                          dir_up_i,
    input  wire logic [STEP_W-1:0]             cur_step_i,
    input  wire logic [STEP_W-1:0]             max_step_i,
    // Modes
    input  wire logic                          reset_mode_i,
    input  wire logic                          enter_low_power_i,
    input  wire logic                          default_supply_enable_i,
    input  wire logic                          first_linreg_on_i,
    // Regulator configuration
    input  wire seq_step_pkg::reg_cfg_s [N_REG-1:0] reg_cfg_i,
    // Output configuration
    input  wire seq_step_pkg::out_cfg_s [N_OUT-1:0] out_cfg_i,
    // Wait step
    input  wire logic [STEP_W-1:0]             wait_step_i,
    input  wire logic                          wait_delay_mode_i,
    input  wire logic [15:0]                   wait_delay_ticks_i,
    input  wire logic                          wait_timeout_en_i,
    input  wire logic                          wait_input_event_flag_i,
    // Group disable
    input  wire logic [STEP_W-1:0]             group_disable_step_i,
    // Outputs
    output logic [N_REG-1:0]                   reg_enable_o,
    output logic [N_REG-1:0]                   reg_sel_b_o,
    output logic [N_OUT-1:0]                   gp_out_o,
    output logic                               group_enable_o,
    output logic                               hold_o,
    output logic                               wait_shutdown_o,
    output logic                               wait_timeout_flag_o
);
    import seq_step_pkg::*;

    wait_state_e       wait_state;
    wait_state_e       next_wait_state;
    logic [31:0]       wait_cnt;
    logic [15:0]       delay_cnt;
    logic [N_OUT-1:0]  out_active;

    wire at_wait      = (wait_step_i != STEP_ZERO) && (cur_step_i == wait_step_i)
                        && (wait_step_i <= max_step_i) && dir_up_i;
    wire holding      = (wait_state == WAIT_HOLD) || (wait_state == WAIT_DELAY);
    wire delay_done   = (delay_cnt >= wait_delay_ticks_i);
    wire timeout_hit  = wait_timeout_en_i && (wait_cnt >= 32'(TIMEOUT_CNT - 1));
    // R20 R23 one evaluation per tick
    // Actions fire once per tick, never while holding
    wire act          = step_tick_i && !holding && !reset_mode_i;
    // R7 R8 step zero gating
    wire step0_ok     = (cur_step_i != STEP_ZERO) || default_supply_enable_i;
    wire keep_first   = default_supply_enable_i && first_linreg_on_i
                        && reg_cfg_i[FIRST_LINREG].keep_cfg
                        && (reg_cfg_i[FIRST_LINREG].step == STEP_ZERO);

    always_comb begin
        next_wait_state = wait_state;
        case (wait_state)
            WAIT_IDLE: begin
                // R15 wait entry
                if (step_tick_i && at_wait && !reset_mode_i)
                    next_wait_state = wait_delay_mode_i ? WAIT_DELAY : WAIT_HOLD;
            end
            WAIT_HOLD: begin
                if (wait_input_event_flag_i || timeout_hit)
                    next_wait_state = WAIT_DONE;
            end
            WAIT_DELAY: begin
                // R18 delay mode
                if (delay_done || timeout_hit)
                    next_wait_state = WAIT_DONE;
            end
            WAIT_DONE: begin
                if (!at_wait)
                    next_wait_state = WAIT_IDLE;
            end
            default: next_wait_state = WAIT_IDLE;
        endcase
        if (reset_mode_i)
            next_wait_state = WAIT_IDLE;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_state <= WAIT_IDLE;
            wait_cnt   <= 32'h0000_0000;
            delay_cnt  <= 16'h0000;
        end else begin
            wait_state <= next_wait_state;
            wait_cnt   <= holding ? wait_cnt + 32'h0000_0001 : 32'h0000_0000;
            if (!holding)
                delay_cnt <= 16'h0000;
            else if (step_tick_i)
                delay_cnt <= delay_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_shutdown_o     <= 1'b0;
            wait_timeout_flag_o <= 1'b0;
        end else begin
            wait_shutdown_o <= 1'b0;
            // R17 timeout shutdown
            if (holding && timeout_hit) begin
                wait_shutdown_o     <= 1'b1;
                wait_timeout_flag_o <= 1'b1;
            end else if (reset_mode_i && !holding) begin
                wait_timeout_flag_o <= wait_timeout_flag_o;
            end
        end
    end

    // R24 hold indication
    assign hold_o = holding || (step_tick_i && at_wait && wait_state == WAIT_IDLE);

    genvar g;
    generate
        for (g = 0; g < N_REG; g++) begin : g_reg
            // R1 R2 R22 per-regulator match
            wire hit = act && (cur_step_i == reg_cfg_i[g].step)
                       && (reg_cfg_i[g].step <= max_step_i) && step0_ok;
            // R6 default supplies
            wire def = enter_low_power_i && default_supply_enable_i
                       && (reg_cfg_i[g].step == STEP_ZERO);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    reg_enable_o[g] <= 1'b0;
                    reg_sel_b_o[g]  <= 1'b0;
                end else if (reset_mode_i) begin
                    // R9 first linear regulator kept on
                    reg_enable_o[g] <= (g == FIRST_LINREG) && keep_first;
                    reg_sel_b_o[g]  <= 1'b0;
                end else if (def) begin
                    reg_enable_o[g] <= 1'b1;
                end else if (hit && dir_up_i) begin
                    // R3 R4 up pass
                    reg_enable_o[g] <= reg_cfg_i[g].auto_ctl || reg_cfg_i[g].keep_cfg;
                    reg_sel_b_o[g]  <= 1'b0;
                end else if (hit) begin
                    // R5 R4 down pass
                    reg_enable_o[g] <= reg_cfg_i[g].keep_cfg;
                    reg_sel_b_o[g]  <= reg_cfg_i[g].keep_cfg;
                end
            end
        end

        for (g = 0; g < N_OUT; g++) begin : g_out
            // R12 R21 valid pointers only
            wire rise_ok = (out_cfg_i[g].assert_step != STEP_ZERO)
                           && (out_cfg_i[g].assert_step <= max_step_i);
            wire fall_ok = (out_cfg_i[g].deassert_step != STEP_ZERO)
                           && (out_cfg_i[g].deassert_step <= max_step_i);
            wire at_rise = act && rise_ok && (cur_step_i == out_cfg_i[g].assert_step);
            wire at_fall = act && fall_ok && (cur_step_i == out_cfg_i[g].deassert_step);
            always_ff @(posedge clk_i) begin
                if (rst_i || reset_mode_i) begin
                    // R11 inactive in reset
                    out_active[g] <= 1'b0;
                end else if (dir_up_i) begin
                    // R10 R13 up pass
                    if (at_rise)
                        out_active[g] <= 1'b1;
                    else if (at_fall)
                        out_active[g] <= 1'b0;
                end else begin
                    // R14 down pass reversed
                    if (at_fall)
                        out_active[g] <= 1'b1;
                    else if (at_rise)
                        out_active[g] <= 1'b0;
                end
            end
            always_ff @(posedge clk_i) begin
                // R13 idle level follows polarity
                if (rst_i)
                    gp_out_o[g] <= ~out_cfg_i[g].polarity;
                else
                    gp_out_o[g] <= out_cfg_i[g].polarity ? next_level(g) : ~next_level(g);
            end
        end
    endgenerate

    function automatic logic next_level(input int idx);
        next_level = out_active[idx];
    endfunction

    // R19 group disable step
    wire grp_ok = (group_disable_step_i != STEP_ZERO) && (group_disable_step_i <= max_step_i);
    always_ff @(posedge clk_i) begin
        if (rst_i || reset_mode_i)
            group_enable_o <= 1'b0;
        else if (act && grp_ok && dir_up_i && cur_step_i > group_disable_step_i)
            group_enable_o <= 1'b1;
        else if (act && grp_ok && !dir_up_i && cur_step_i < group_disable_step_i)
            group_enable_o <= 1'b0;
    end

endmodule // sequencer_step_actions
`default_nettype wire

// File: rtl/seq_step_pkg.sv
`default_nettype none
package seq_step_pkg;
    localparam int          STEP_W        = 4;
    localparam int          NUM_STEPS     = 16;
    localparam int          NUM_REGS      = 7;
    localparam int          NUM_OUTS      = 5;
    localparam int          CLK_HZ        = 20_000_000;
    localparam int          TIMEOUT_MS    = 500;
    localparam int          TIMEOUT_CYC   = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int          PERIOD_MIN_US = 32;
    localparam int          PERIOD_MAX_US = 8192;
    localparam logic [3:0]  STEP_ZERO     = 4'h0;
    localparam logic [3:0]  FIRST_LINREG  = 4'h3;

    typedef enum logic [1:0] {
        WAIT_IDLE  = 2'b00,
        WAIT_HOLD  = 2'b01,
        WAIT_DELAY = 2'b11,
        WAIT_DONE  = 2'b10
    } wait_state_e;

    typedef struct packed {
        logic            auto_ctl;
        logic            keep_cfg;
        logic [STEP_W-1:0] step;
    } reg_cfg_s;

    typedef struct packed {
        logic              polarity;
        logic [STEP_W-1:0] assert_step;
        logic [STEP_W-1:0] deassert_step;
    } out_cfg_s;
endpackage
`default_nettype wire

// File: verification/seq_step_checker.sv
`default_nettype none
module seq_step_checker
    import seq_step_pkg::*;
#(parameter int N_REG = NUM_REGS, parameter int N_OUT = NUM_OUTS) (
    input wire logic clk_i, rst_i, step_tick_i, dir_up_i, reset_mode_i, hold_o,
    input wire logic enter_low_power_i, wait_timeout_en_i, wait_delay_mode_i,
    input wire logic wait_input_event_flag_i, wait_shutdown_o, group_enable_o,
    input wire logic [STEP_W-1:0] cur_step_i, max_step_i, wait_step_i, group_disable_step_i,
    input wire seq_step_pkg::reg_cfg_s [N_REG-1:0] reg_cfg_i,
    input wire seq_step_pkg::out_cfg_s [N_OUT-1:0] out_cfg_i,
    input wire logic [N_REG-1:0] reg_enable_o, reg_sel_b_o,
    input wire logic [N_OUT-1:0] gp_out_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reg_cfg_s c0;
    logic     go, hit, gok;
    // Ticks at the wait step are skipped: that step acts on its tick and may then hold
    assign c0 = reg_cfg_i[0];
    assign go = step_tick_i && !hold_o && !reset_mode_i && cur_step_i != wait_step_i;
    assign hit = go && c0.step == cur_step_i && c0.step != 0 && c0.step <= max_step_i;
    assign gok = go && group_disable_step_i != 0 && group_disable_step_i <= max_step_i;
    a_reg_up_on: assert property (hit && dir_up_i && (c0.auto_ctl || c0.keep_cfg)
        |=> reg_enable_o[0] && !reg_sel_b_o[0]) else $error("reg up on");
    a_reg_up_off: assert property (hit && dir_up_i && !c0.auto_ctl && !c0.keep_cfg
        |=> !reg_enable_o[0] && !reg_sel_b_o[0]) else $error("reg up off");
    a_reg_down_b: assert property (hit && !dir_up_i && c0.keep_cfg
        |=> reg_enable_o[0] && reg_sel_b_o[0]) else $error("reg down b");
    a_reset_idle: assert property (reset_mode_i [*2]
        |=> gp_out_o[0] == !out_cfg_i[0].polarity && !reg_enable_o[0]) else $error("reset idle");
    a_wait_expiry: assert property ($rose(hold_o) && wait_timeout_en_i && !wait_delay_mode_i
        && !wait_input_event_flag_i |-> ##[1:60] wait_shutdown_o) else $error("wait timeout");
    a_group_up: assert property (gok && dir_up_i && cur_step_i > group_disable_step_i
        |=> group_enable_o) else $error("group up");
    a_group_down: assert property (gok && !dir_up_i && cur_step_i < group_disable_step_i
        |=> !group_enable_o) else $error("group down");
    a_quiet_keep: assert property ((!step_tick_i || (hold_o && $past(hold_o)))
        && !reset_mode_i && !enter_low_power_i && !wait_shutdown_o
        |=> $stable(reg_enable_o)) else $error("reg moved");
endmodule // seq_step_checker
bind sequencer_step_actions seq_step_checker #(.N_REG(N_REG), .N_OUT(N_OUT)) chk (.clk_i,
    .rst_i, .step_tick_i, .dir_up_i, .reset_mode_i, .hold_o, .enter_low_power_i,
    .wait_timeout_en_i, .wait_delay_mode_i, .wait_input_event_flag_i, .wait_shutdown_o,
    .group_enable_o, .cur_step_i, .max_step_i, .wait_step_i, .group_disable_step_i,
    .reg_cfg_i, .out_cfg_i, .reg_enable_o, .reg_sel_b_o, .gp_out_o);
`default_nettype wire

// File: verification/supply_rails.sv
`default_nettype none
module supply_rails #(parameter int N = 7) (
    input  wire logic         clk_i,
    input  wire logic [N-1:0] en_i,
    output logic      [N-1:0] good_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [N-1:0] half;
    // Two-cycle soft start; a rail drops as soon as its enable goes
    always @(posedge clk_i) begin
        half <= en_i;
        good_o <= en_i & half;
    end
endmodule // supply_rails
`default_nettype wire

// File: verification/sequencer_step_actions_bench.sv
`default_nettype none
module sequencer_step_actions_bench
    import seq_step_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, tick = 0, up = 1, rmode = 0, lowp = 0, defs = 0, wto = 0;
    logic lin = 0, dmode = 0, evt = 0;
    logic [15:0] dly = 16'h0000;
    logic [3:0] cur = 0, wst = 0, gst = 4'h7, mx = 4'hf;
    reg_cfg_s [6:0] rc = '0;
    out_cfg_s [4:0] oc = '0;
    logic [6:0] en, sb, good;
    logic [4:0] gp;
    logic       ge, hold, shut, tflag;
    logic [7:0] lf = 8'h0d;
    int mismatches = 0, num_checks = 0, cyc = 0, n;
    bit e_en[7], e_sb[7], e_act[5], e_g;
    initial forever #25 clk_i = ~clk_i;
    sequencer_step_actions #(.TIMEOUT_CNT(50)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .step_tick_i(tick), .dir_up_i(up), .cur_step_i(cur), .max_step_i(mx),
        .reset_mode_i(rmode), .enter_low_power_i(lowp), .default_supply_enable_i(defs),
        .first_linreg_on_i(lin), .reg_cfg_i(rc), .out_cfg_i(oc), .wait_step_i(wst),
        .wait_delay_mode_i(dmode), .wait_delay_ticks_i(dly), .wait_timeout_en_i(wto),
        .wait_input_event_flag_i(evt), .group_disable_step_i(gst), .reg_enable_o(en),
        .reg_sel_b_o(sb), .gp_out_o(gp), .group_enable_o(ge), .hold_o(hold),
        .wait_shutdown_o(shut), .wait_timeout_flag_o(tflag));
    supply_rails #(.N(7)) rails (.clk_i(clk_i), .en_i(en), .good_o(good));
    function automatic logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        num_checks++;
        if (e !== s) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(bit all);
        logic [6:0] xe, xs;
        logic [4:0] xg;
        foreach (e_en[i]) xe[i] = e_en[i];
        foreach (e_sb[i]) xs[i] = e_sb[i];
        chk("enable", xe, en);
        if (all) chk("sel_b", xs, sb);
        if (all) chk("group", e_g, ge);
        @(negedge clk_i);
        foreach (e_act[i]) xg[i] = e_act[i] ~^ oc[i].polarity;
        chk("gp_out", xg, gp);
    endtask
    task automatic step(logic [3:0] s, bit d);
        @(posedge clk_i);
        cur <= s;
        up <= d;
        tick <= 1;
        @(posedge clk_i);
        tick <= 0;
        foreach (e_en[i]) if (rc[i].step == s && (s != 0 || defs)) begin
            e_en[i] = d ? rc[i].auto_ctl | rc[i].keep_cfg : rc[i].keep_cfg;
            e_sb[i] = !d && rc[i].keep_cfg;
        end
        foreach (e_act[i]) if (s != 0) begin
            if (oc[i].assert_step == s) e_act[i] = d;
            if (oc[i].deassert_step == s) e_act[i] = !d;
        end
        if (d ? s > gst : s < gst) e_g = d;
        @(negedge clk_i);
        cmp(1);
    endtask
    initial begin
        foreach (oc[i]) begin
            oc[i] = 9'({rnd(), rnd()});
            oc[i].deassert_step = oc[i].assert_step ^ 4'h5;
        end
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        repeat (3) @(negedge clk_i);
        cmp(1);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            foreach (rc[i]) rc[i] <= 6'(rnd());
            for (int s = 1; s < 16; s++) step(4'(s), 1);
            for (int s = 15; s > 0; s--) step(4'(s), 0);
        end
        @(posedge clk_i);
        defs <= 1;
        rc[0].step <= 0;
        lowp <= 1;
        @(posedge clk_i);
        lowp <= 0;
        // Every step zero regulator is a default supply, not only the first
        foreach (e_en[i]) if (rc[i].step == 0) e_en[i] = 1;
        @(negedge clk_i);
        cmp(1);
        step(0, 0);
        @(posedge clk_i);
        defs <= 0;
        step(0, 1);
        @(posedge clk_i);
        wst <= 4'h5;
        wto <= 1;
        for (int s = 1; s < 5; s++) step(4'(s), 1);
        @(posedge clk_i);
        cur <= 4'h5;
        tick <= 1;
        @(posedge clk_i);
        tick <= 0;
        @(negedge clk_i);
        chk("hold", 1, hold);
        n = 0;
        while (shut !== 1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        chk("shutdown", 1, n > 40 && shut === 1);
        @(negedge clk_i);
        chk("timeout flag", 1, tflag);
        @(posedge clk_i);
        rmode <= 1;
        repeat (3) @(posedge clk_i);
        foreach (e_en[i]) e_en[i] = 0;
        foreach (e_act[i]) e_act[i] = 0;
        foreach (e_sb[i]) e_sb[i] = 0;
        e_g = 0;
        @(negedge clk_i);
        cmp(0);
        chk("rails", 0, good);
        @(posedge clk_i);
        rc[3].keep_cfg <= 1;
        rc[3].step <= 0;
        defs <= 1;
        lin <= 1;
        repeat (3) @(posedge clk_i);
        e_en[3] = 1;
        @(negedge clk_i);
        cmp(0);
        @(posedge clk_i);
        rmode <= 0;
        defs <= 0;
        lin <= 0;
        wto <= 0;
        for (int s = 1; s < 6; s++) step(4'(s), 1);
        chk("hold", 1, hold);
        @(posedge clk_i);
        cur <= 4'h6;
        tick <= 1;
        @(posedge clk_i);
        tick <= 0;
        @(negedge clk_i);
        cmp(1);
        @(posedge clk_i);
        evt <= 1;
        @(posedge clk_i);
        @(negedge clk_i);
        chk("hold released", 0, hold);
        @(posedge clk_i);
        evt <= 0;
        step(4'h6, 1);
        @(posedge clk_i);
        dmode <= 1;
        dly <= 16'h0003;
        step(4'h5, 1);
        chk("delay entry", 1, hold);
        for (int t = 0; t < 3; t++) begin
            @(posedge clk_i);
            tick <= 1;
            @(posedge clk_i);
            tick <= 0;
        end
        @(negedge clk_i);
        chk("delay hold", 1, hold);
        @(posedge clk_i);
        @(negedge clk_i);
        chk("delay over", 0, hold);
        cmp(1);
        give_verdict();
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            give_verdict();
        end
    end
endmodule // sequencer_step_actions_bench
`default_nettype wire
